// ---- hw/dpc_defines.svh ----
`ifndef DPC_DEFINES_SVH
`define DPC_DEFINES_SVH

// Serial frame geometry, most significant bit first.
`define DPC_FRAME_BITS   24
`define DPC_FRAME_LAST   5'h17
`define DPC_FRAME_FULL   5'h18
`define DPC_OP_MSB       23
`define DPC_ADDR_MSB     19
`define DPC_DATA_MSB     15

// Wiper range and nonvolatile store shape.
`define DPC_WIPER_BITS   10
`define DPC_WIPER_ZERO   10'h000
`define DPC_WIPER_ONE    10'h001
`define DPC_WIPER_FULL   10'h3FF
`define DPC_WIPER_MID    10'h200
`define DPC_STORE_WORDS  16
`define DPC_SLOT_WIPER   4'h0

// Reset values of the link bookkeeping.
`define DPC_TOG_RESET    1'h1

`endif

// ---- hw/dpc_pkg.sv ----
package dpc_pkg;

    // Command codes carried in the top four bits of a frame.
    typedef enum logic [3:0] {
        DPC_OP_NOP      = 4'h0, DPC_OP_RESTORE  = 4'h1, DPC_OP_STORE    = 4'h2,
        DPC_OP_USER_WR  = 4'h3, DPC_OP_HALVE    = 4'h4, DPC_OP_HALVE_X  = 4'h5,
        DPC_OP_DEC      = 4'h6, DPC_OP_DEC_X    = 4'h7, DPC_OP_RELOAD   = 4'h8,
        DPC_OP_RD_STORE = 4'h9, DPC_OP_RD_WIPER = 4'hA, DPC_OP_LOAD     = 4'hB,
        DPC_OP_DOUBLE   = 4'hC, DPC_OP_DOUBLE_X = 4'hD, DPC_OP_INC      = 4'hE,
        DPC_OP_INC_X    = 4'hF
    } dpc_op_t;

    // One received frame: command, address and data fields.
    typedef struct packed {
        dpc_op_t     op;
        logic [3:0]  addr;
        logic [15:0] data;
    } dpc_frame_t;

    // Control sequencer states.
    typedef enum logic {DPC_ST_BOOT, DPC_ST_RUN} dpc_state_t;

endpackage : dpc_pkg

// ---- hw/dpc_cmd_decoder.sv ----
`timescale 1ns/10ps
`include "dpc_defines.svh"
// How it works
// R1 - Frames are 24 bits, MSB first: command, address, then sixteen data bits.
// R2 - Bits are counted per frame; only whole multiples of 24 execute.
// R3 - A command executes only when chip select returns high.
// R4 - Code 0 changes nothing but the read power state, which it turns off; address and data are ignored.
// R5 - Code 1 at address 0 copies store slot 0 into the wiper.
// R6 - Code 1 leaves the read power state on until a no-op.
// R7 - Code 2 at address 0 copies the wiper into store slot 0.
// R8 - Code 3 writes the sixteen data bits to the addressed store word.
// R9 - Code 3 at address 0: only the low ten bits matter as wiper.
// R10 - Codes 4 and 5 halve the wiper; code 5 ignores the address.
// R11 - Codes 6 and 7 step the wiper down; code 7 ignores the address.
// R12 - Code 8 reloads the wiper from store slot 0 whatever the fields.
// R13 - Code 9 selects a store word for readback in the next frame.
// R14 - Code 10 at address 0 selects the wiper for readback next frame.
// R15 - Code 11 at address 0 loads the low ten data bits into the wiper.
// R16 - Codes 12 and 13 double the wiper; code 13 ignores the address.
// R17 - Doubling zero gives one; doubling midscale or more gives full scale.
// R18 - Codes 14 and 15 step the wiper up; code 15 ignores the address.
// R19 - Step and shift commands ignore both data bytes.
// R20 - Serial out normally echoes the last 24 bits shifted in.
// R21 - After a read, the data bytes of the next frame carry the value.
// R22 - The wiper is volatile and loads from store slot 0 at power-on.
// R23 - A chip select pulse without clocks repeats the last command.
// R24 - Single steps saturate at 1023 and at zero without wrapping.
// R25 - Halving shifts right with a zero entering at the top.
module dpc_cmd_decoder #(
    parameter logic [15:0] SLOT0_INIT = 16'h0200
) (
    input  wire logic            clk,
    input  wire logic            rst_b,
    input  wire logic            sclk,
    input  wire logic            cs_n,
    input  wire logic            sdi,
    output logic                 sdo_o,
    output logic                 sdo_oe,
    output logic [9:0]           wiper_o,
    output logic                 read_power_o,
    output dpc_pkg::dpc_frame_t  last_frame_o
);
    import dpc_pkg::*;

    // Codes that only act with a zero address field.
    // Any other address turns these codes into a recorded no-op.
    function automatic logic needs_zero(input dpc_op_t op);
        needs_zero = (op == DPC_OP_RESTORE) || (op == DPC_OP_STORE) ||
                     (op == DPC_OP_HALVE) || (op == DPC_OP_DEC) ||
                     (op == DPC_OP_RD_WIPER) || (op == DPC_OP_LOAD) ||
                     (op == DPC_OP_DOUBLE) || (op == DPC_OP_INC);
    endfunction : needs_zero

    // ---------------- Link domain, clocked by the host's serial clock.
    // The serial clock stops while chip select is high, so these flops hold
    // still across the frame end; they carry power-up values instead of a reset.
    // Nothing here is read by the control domain while the clock runs, and the
    // control domain changes nothing that these flops read until chip select is
    // high again, so the frame-end handshake is the only crossing needed.
    // The bit counter wraps to zero after every 24th bit, so zero at frame end
    // means a whole number of frames arrived.
    // A mode 3 host idles the clock high; its first falling edge changes nothing.
    logic [23:0] shift_r = '0;
    logic [4:0]  phase_r = '0;
    logic [4:0]  fbits_r = '0;
    logic        seen_r  = 1'b0;

    // Words handed from the control domain stay fixed while a frame runs.
    logic        frame_tog_r;
    logic        rd_pending_r;
    logic [23:0] rd_word_r;

    wire         new_frame = (seen_r != frame_tog_r);
    wire  [4:0]  out_idx   = new_frame ? 5'h00 : fbits_r;
    wire         rd_on     = rd_pending_r && (out_idx < `DPC_FRAME_FULL);
    wire  [4:0]  rd_bit    = `DPC_FRAME_LAST - out_idx;
    wire         out_bit   = rd_on ? rd_word_r[rd_bit] : shift_r[`DPC_OP_MSB];

    // Shift in on the rising edge and keep the bit position within the frame.
    always_ff @(posedge sclk) begin
        shift_r <= {shift_r[22:0], sdi}; // R1 R20
        seen_r  <= frame_tog_r;
        phase_r <= new_frame ? 5'h01
                 : (phase_r == `DPC_FRAME_LAST) ? 5'h00
                 : 5'(phase_r + 5'h01); // R2
        fbits_r <= (out_idx == `DPC_FRAME_FULL) ? out_idx : 5'(out_idx + 5'h01);
    end

    // Open-drain serial out: pulls low only while selected and the bit is 0.
    // With chip select high the pin is always released to the pull-up.
    assign sdo_o  = 1'b0;
    assign sdo_oe = !cs_n && !out_bit; // R20 R21

    // ---------------- Control domain.
    logic       cs_s1_r, cs_s2_r, cs_s3_r;
    logic       cs_high_r;
    dpc_state_t state_r;
    logic [9:0] wiper_r;
    logic       ran_r;
    logic       power_r;
    dpc_frame_t last_r;
    logic       exec_r;
    logic [15:0] store_r [`DPC_STORE_WORDS];

    // Chip select passes three flops; a change counts when the last two agree.
    // The first flop may go metastable, so only the second and third are compared,
    // and a glitch shorter than one clock never reaches the command logic.
    // Chip select is held high through reset, so no false rise follows release.
    always_ff @(posedge clk) begin
        cs_s1_r <= cs_n;
        cs_s2_r <= cs_s1_r;
        cs_s3_r <= cs_s2_r;
        if (!rst_b) begin
            cs_high_r <= 1'b1;
        end else if (cs_s2_r == cs_s3_r) begin
            cs_high_r <= cs_s3_r;
        end
    end

    // Frame end: link flops are frozen now, so they are read directly.
    // A frame that was clocked runs only when its bit count is aligned; a bare
    // chip select pulse replays the last command once one has run since reset.
    // Odd bit counts are dropped without touching the replay record.
    wire        cs_rise   = (cs_s2_r == cs_s3_r) && cs_s3_r && !cs_high_r;
    wire        clocked   = (seen_r == frame_tog_r);
    wire        aligned   = (phase_r == `DPC_FRAME_LAST + 5'h01) || (phase_r == 5'h00);
    wire        repeat_go = !clocked && ran_r; // R23
    wire        go        = (state_r == DPC_ST_RUN) && cs_rise &&
                            ((clocked && aligned) || repeat_go); // R2 R3
    dpc_frame_t cur;
    assign cur = clocked ? dpc_frame_t'(shift_r) : last_r;
    wire        addr_ok   = !needs_zero(cur.op) || (cur.addr == `DPC_SLOT_WIPER);
    wire        act       = go && addr_ok;
    wire [9:0]  slot0     = store_r[`DPC_SLOT_WIPER][9:0]; // R9

    // Wiper arithmetic for steps and shifts, data bytes unused.
    // Every result stays inside 0 to 1023, so no step can wrap around.
    // Doubling is a left shift with its two corner cases forced.
    wire [9:0]  w_inc  = (wiper_r == `DPC_WIPER_FULL) ? wiper_r : 10'(wiper_r + 10'h001);
    wire [9:0]  w_dec  = (wiper_r == `DPC_WIPER_ZERO) ? wiper_r : 10'(wiper_r - 10'h001);
    wire [9:0]  w_half = {1'b0, wiper_r[9:1]}; // R10 R25
    wire [9:0]  w_dbl  = (wiper_r == `DPC_WIPER_ZERO) ? `DPC_WIPER_ONE
                       : (wiper_r >= `DPC_WIPER_MID) ? `DPC_WIPER_FULL
                       : {wiper_r[8:0], 1'b0}; // R16 R17

    // Next wiper value chosen by the executed command.
    // The boot cycle after reset copies slot 0, as a power cycle would.
    logic [9:0] wiper_nxt;
    always_comb begin
        wiper_nxt = wiper_r;
        if (state_r == DPC_ST_BOOT) begin
            wiper_nxt = slot0; // R22
        end else if (act) begin
            unique case (cur.op)
                DPC_OP_RESTORE, DPC_OP_RELOAD: wiper_nxt = slot0; // R5 R12
                DPC_OP_HALVE, DPC_OP_HALVE_X:  wiper_nxt = w_half; // R10 R19
                DPC_OP_DEC, DPC_OP_DEC_X:      wiper_nxt = w_dec; // R11 R24
                DPC_OP_LOAD:                   wiper_nxt = cur.data[9:0]; // R15
                DPC_OP_DOUBLE, DPC_OP_DOUBLE_X: wiper_nxt = w_dbl; // R16
                DPC_OP_INC, DPC_OP_INC_X:      wiper_nxt = w_inc; // R18 R24
                DPC_OP_NOP, DPC_OP_STORE, DPC_OP_USER_WR, DPC_OP_RD_STORE,
                DPC_OP_RD_WIPER:               wiper_nxt = wiper_r; // R4
            endcase
        end
    end

    // Store write strobes: code 2 saves the wiper, code 3 writes user data.
    // Only one of the two can fire for a frame, so one write port serves both.
    wire        st_save = act && (cur.op == DPC_OP_STORE); // R7
    wire        st_user = act && (cur.op == DPC_OP_USER_WR); // R8
    wire [3:0]  st_addr = st_save ? `DPC_SLOT_WIPER : cur.addr;
    wire [15:0] st_data = st_save ? {6'h00, wiper_r} : cur.data;
    wire        rd_sel  = act && ((cur.op == DPC_OP_RD_STORE) ||
                                  (cur.op == DPC_OP_RD_WIPER)); // R13 R14
    wire [15:0] rd_val  = (cur.op == DPC_OP_RD_WIPER) ? {6'h00, wiper_r}
                        : store_r[cur.addr];

    // Nonvolatile words; slot 0 starts at its preset value on power-up.
    // Reset stands in for a power cycle here, which is why reset presets slot 0 and clears the other words.
    genvar gi;
    generate
        for (gi = 0; gi < `DPC_STORE_WORDS; gi++) begin : g_store
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    store_r[gi] <= (gi == 0) ? SLOT0_INIT : 16'h0000;
                end else if ((st_save || st_user) && st_addr == 4'(gi)) begin
                    store_r[gi] <= st_data; // R7 R8
                end
            end
        end
    endgenerate

    // Sequencer: one boot cycle loads the wiper, then frames are served.
    // Frames that end during the boot cycle are not served.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_r <= DPC_ST_BOOT;
        end else begin
            state_r <= DPC_ST_RUN;
        end
    end

    // Wiper, power state and command history.
    // The history is what a bare chip select pulse replays, so only executed
    // frames enter it.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wiper_r <= `DPC_WIPER_ZERO;
            power_r <= 1'b0;
            ran_r   <= 1'b0;
            last_r  <= '0;
            exec_r  <= 1'b0;
        end else begin
            wiper_r <= wiper_nxt;
            exec_r  <= go; // R3
            if (go) begin
                ran_r  <= 1'b1;
                last_r <= cur; // R23
            end
            if (act && cur.op == DPC_OP_RESTORE) begin
                power_r <= 1'b1; // R6
            end else if (go && cur.op == DPC_OP_NOP) begin
                power_r <= 1'b0; // R6
            end
        end
    end

    // Readback selection lives for exactly the next frame.
    // Every chip select rise re-arms or clears it, so a stale selection never
    // reaches a later frame; the toggle tells the link side a new frame begins.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            frame_tog_r  <= `DPC_TOG_RESET;
            rd_pending_r <= 1'b0;
            rd_word_r    <= '0;
        end else if (cs_rise) begin
            frame_tog_r  <= !frame_tog_r;
            rd_pending_r <= rd_sel; // R21
            rd_word_r    <= {cur.op, cur.addr, rd_val}; // R13 R14
        end
    end

    assign wiper_o      = wiper_r;
    assign read_power_o = power_r;
    assign last_frame_o = last_r;

    // ---------------- Checks.
    // Checks look one clock after execution, when results have landed.
    // Reset disables every check, so the first edge after release is the first seen.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    dpc_op_t ex_op;
    assign ex_op = last_r.op;
    wire ex_zero = (last_r.addr == `DPC_SLOT_WIPER);

    only_at_end_a: assert property (exec_r |-> $past(cs_rise)) // R3
        else $error("command executed without a chip select rise");
    nop_holds_a: assert property (exec_r && ex_op == DPC_OP_NOP |->
        wiper_r == $past(wiper_r) && !read_power_o) // R4 R6
        else $error("no-op changed the wiper or power state");
    restore_wiper_a: assert property (exec_r && ex_zero &&
        (ex_op == DPC_OP_RESTORE || ex_op == DPC_OP_RELOAD) |->
        wiper_r == $past(store_r[0][9:0])) // R5 R12
        else $error("restore did not copy slot 0");
    save_slot_a: assert property (exec_r && ex_zero && ex_op == DPC_OP_STORE |->
        store_r[0] == {6'h00, $past(wiper_r)}) // R7
        else $error("store did not save the wiper");
    user_write_a: assert property (exec_r && ex_op == DPC_OP_USER_WR |->
        store_r[last_r.addr] == last_r.data) // R8
        else $error("user word not written");
    halve_step_a: assert property (exec_r && (ex_op == DPC_OP_HALVE_X) |->
        wiper_r == ($past(wiper_r) >> 1)) // R10 R25
        else $error("halving result wrong");
    step_down_a: assert property (exec_r && ex_op == DPC_OP_DEC_X |->
        wiper_r == (($past(wiper_r) == 10'h000) ? 10'h000 : $past(wiper_r) - 10'h001)) // R11
        else $error("step down result wrong");
    double_step_a: assert property (exec_r && ex_op == DPC_OP_DOUBLE_X |->
        wiper_r == (($past(wiper_r) == 10'h000) ? 10'h001 :
        ($past(wiper_r) >= 10'h200) ? 10'h3FF : {$past(wiper_r[8:0]), 1'b0})) // R17
        else $error("doubling result wrong");
    step_up_a: assert property (exec_r && ex_op == DPC_OP_INC_X |->
        wiper_r == (($past(wiper_r) == 10'h3FF) ? 10'h3FF : $past(wiper_r) + 10'h001)) // R18 R24
        else $error("step up result wrong");
    load_wiper_a: assert property (exec_r && ex_zero && ex_op == DPC_OP_LOAD |->
        wiper_r == last_r.data[9:0]) // R15
        else $error("direct load wrong");
    boot_load_a: assert property ($rose(rst_b) |=> wiper_r == store_r[0][9:0]) // R22
        else $error("wiper not loaded at power-on");

    // Address-zero forms of the shift and step codes behave like the free forms.
    // Their data bytes never enter the result.
    halve_zero_a: assert property (exec_r && ex_zero && ex_op == DPC_OP_HALVE |-> // R10 R25
        wiper_r == ($past(wiper_r) >> 1))
        else $error("address-zero halving result wrong");
    step_down_zero_a: assert property (exec_r && ex_zero && ex_op == DPC_OP_DEC |-> // R11 R24
        wiper_r == (($past(wiper_r) == 10'h000) ? 10'h000 : $past(wiper_r) - 10'h001))
        else $error("address-zero step down result wrong");
    double_zero_a: assert property (exec_r && ex_zero && ex_op == DPC_OP_DOUBLE |-> // R16 R17
        wiper_r == (($past(wiper_r) == 10'h000) ? 10'h001 :
        ($past(wiper_r) >= 10'h200) ? 10'h3FF : {$past(wiper_r[8:0]), 1'b0}))
        else $error("address-zero doubling result wrong");
    step_up_zero_a: assert property (exec_r && ex_zero && ex_op == DPC_OP_INC |-> // R18 R24
        wiper_r == (($past(wiper_r) == 10'h3FF) ? 10'h3FF : $past(wiper_r) + 10'h001))
        else $error("address-zero step up result wrong");
    reload_any_a: assert property (exec_r && ex_op == DPC_OP_RELOAD |-> // R12
        wiper_r == $past(store_r[0][9:0]))
        else $error("reload ignored slot 0");

    // Codes that need address zero must change nothing when given another one.
    // Only the replay record may move.
    addr_refuse_a: assert property (exec_r && !ex_zero && needs_zero(ex_op) |-> // R5 R7 R15
        wiper_r == $past(wiper_r) && store_r[0] == $past(store_r[0]) &&
        read_power_o == $past(read_power_o) && !rd_pending_r)
        else $error("address-zero code acted on another address");
    read_keeps_a: assert property (exec_r && (ex_op == DPC_OP_USER_WR || // R8 R13 R14
        ex_op == DPC_OP_RD_STORE || ex_op == DPC_OP_RD_WIPER || ex_op == DPC_OP_STORE) |->
        wiper_r == $past(wiper_r))
        else $error("store or read command moved the wiper");

    // The read power state moves only at an executed restore or no-op.
    power_set_a: assert property (exec_r && ex_zero && ex_op == DPC_OP_RESTORE |-> // R6
        read_power_o)
        else $error("restore left the read power state off");
    power_hold_a: assert property (!exec_r |-> $stable(read_power_o)) // R6
        else $error("read power state moved without a command");

    // A read arms the next frame with the selected word; anything else clears it.
    read_arm_a: assert property (exec_r && (ex_op == DPC_OP_RD_STORE || // R13 R14
        (ex_op == DPC_OP_RD_WIPER && ex_zero)) |-> rd_pending_r)
        else $error("read command did not arm readback");
    read_word_a: assert property (exec_r && ex_op == DPC_OP_RD_STORE |-> // R13
        rd_word_r == {last_r.op, last_r.addr, store_r[last_r.addr]})
        else $error("store readback word wrong");
    read_wiper_a: assert property (exec_r && ex_zero && ex_op == DPC_OP_RD_WIPER |-> // R14
        rd_word_r[15:0] == {6'h00, wiper_r})
        else $error("wiper readback word wrong");
    read_drop_a: assert property ($past(cs_rise) && !$past(rd_sel) |-> !rd_pending_r) // R21
        else $error("readback stayed armed");
    read_hold_a: assert property (!$past(cs_rise) |-> $stable(rd_pending_r)) // R21
        else $error("readback arming moved inside a frame");
    tog_flip_a: assert property (cs_rise |=> frame_tog_r != $past(frame_tog_r)) // R21
        else $error("frame toggle missed a frame end");
    tog_hold_a: assert property (!$past(cs_rise) |-> $stable(frame_tog_r)) // R21
        else $error("frame toggle moved inside a frame");

    // Slot 0 changes only by a store command or a user write.
    store_keep_a: assert property (!(exec_r && (ex_op == DPC_OP_STORE || // R7 R8
        ex_op == DPC_OP_USER_WR)) |-> $stable(store_r[0]))
        else $error("slot 0 changed without a store command");

    // Frame counting, replay and the serial out pin.
    odd_frame_a: assert property ($past(cs_rise && clocked && !aligned) |-> !exec_r) // R2
        else $error("frame with an odd bit count executed");
    repeat_same_a: assert property (exec_r && $past(!clocked) |-> // R23
        last_frame_o == $past(last_frame_o))
        else $error("replay changed the command record");
    last_rec_a: assert property (exec_r |-> last_frame_o == $past(cur)) // R23
        else $error("command record does not match the executed frame");
    one_rise_a: assert property (cs_rise |=> !cs_rise) // R3
        else $error("one chip select rise seen twice");
    wiper_quiet_a: assert property (!exec_r && $past(state_r) == DPC_ST_RUN |-> // R3
        $stable(wiper_r))
        else $error("wiper moved without a command");
    boot_once_a: assert property (state_r == DPC_ST_RUN |=> state_r == DPC_ST_RUN) // R22
        else $error("sequencer left the run state");
    sdo_release_a: assert property (cs_n |-> !sdo_oe) // R21
        else $error("serial out driven while deselected");

    cover_read_c:   cover property (exec_r && ex_op == DPC_OP_RD_WIPER ##[1:200] exec_r);
    cover_repeat_c: cover property (exec_r ##[1:200] exec_r && $past(!clocked, 1));
    cover_full_c:   cover property (exec_r && wiper_r == 10'h3FF);
    cover_user_c:   cover property (exec_r && ex_op == DPC_OP_USER_WR);
    cover_odd_c:    cover property (cs_rise && clocked && !aligned);

endmodule : dpc_cmd_decoder

// ---- test/dpc_host_model.sv ----
`timescale 1ns/10ps
// Serial host on the far side; it owns the link clock, which only toggles inside frames.
module dpc_host_model (
    output logic     sclk,
    output logic     cs_n,
    output logic     sdi,
    input wire logic sdo_line
);
    // The link rests with chip select high and the clock low.
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi  = 1'b0;
    end

    // Shifts n bits MSB first in mode 0 and samples the far side just before each rise.
    task automatic xfer(input logic [47:0] bits, input int n, output logic [47:0] got);
        got  = 48'h0;
        cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            sdi = bits[i];
            #24;
            got[i] = sdo_line;
            sclk = 1'b1;
            #24;
            sclk = 1'b0;
        end
        #24;
        cs_n = 1'b1;
        sdi  = ~sdi;
        #400; // Gap of ten control clocks lets the frame settle.
    endtask : xfer

    // Pulses chip select with the link clock stopped.
    task automatic pulse;
        cs_n = 1'b0;
        #96;
        cs_n = 1'b1;
        #400;
    endtask : pulse
endmodule : dpc_host_model

// ---- test/testbench.sv ----
`timescale 1ns/10ps
module testbench;
    import dpc_pkg::*;

    logic        clk;
    logic        rst_b;
    logic        sclk;
    logic        cs_n;
    logic        sdi;
    logic        sdo_o;
    logic        sdo_oe;
    logic [9:0]  wiper;
    logic        rd_pwr;
    dpc_frame_t  last_frame;
    logic [47:0] got;
    int          n_fail;
    int          comparisons;
    wire logic   sdo_line;

    // The data line has a pull-up, so it reads high whenever the device lets go.
    assign sdo_line = sdo_oe ? sdo_o : 1'b1;

    dpc_cmd_decoder #(.SLOT0_INIT(16'h8123)) u_dut (
        .clk          (clk),
        .rst_b        (rst_b),
        .sclk         (sclk),
        .cs_n         (cs_n),
        .sdi          (sdi),
        .sdo_o        (sdo_o),
        .sdo_oe       (sdo_oe),
        .wiper_o      (wiper),
        .read_power_o (rd_pwr),
        .last_frame_o (last_frame)
    );

    dpc_host_model u_host (
        .sclk     (sclk),
        .cs_n     (cs_n),
        .sdi      (sdi),
        .sdo_line (sdo_line)
    );

    // Control clock at 25 MHz.
    always #20 clk = ~clk;

    // Compares one value and reports a mismatch at once.
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Prints the counts and the verdict, then stops the run.
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict

    // Sends one 24-bit command frame.
    task automatic cmd(input logic [3:0] op, input logic [3:0] a, input logic [15:0] d);
        u_host.xfer({24'h0, op, a, d}, 24, got);
    endtask : cmd

    // Sends one frame and compares the wiper afterwards.
    task automatic step(input logic [3:0] op, input logic [3:0] a, input logic [15:0] d,
                        input logic [9:0] e);
        cmd(op, a, d);
        check({38'h0, wiper}, {38'h0, e});
    endtask : step

    // A hang ends the run as a failure.
    initial begin
        #300000;
        n_fail++;
        give_verdict();
    end

    // Main sequence.
    initial begin
        clk         = 1'b0;
        rst_b       = 1'b0;
        n_fail      = 0;
        comparisons = 0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge clk);
        check({38'h0, wiper}, {38'h0, 10'h123});
        step(4'hB, 4'h0, 16'hFFFE, 10'h3FE);
        check({24'h0, last_frame}, 48'hB0FFFE);
        step(4'hE, 4'h0, 16'h0000, 10'h3FF);
        step(4'hF, 4'h5, 16'hFFFF, 10'h3FF);
        step(4'hC, 4'h0, 16'h0000, 10'h3FF);
        cmd(4'hB, 4'h0, 16'h0200);
        step(4'hD, 4'h9, 16'h0000, 10'h3FF);
        cmd(4'hB, 4'h0, 16'h0000);
        step(4'hC, 4'h0, 16'h0000, 10'h001);
        step(4'hD, 4'h3, 16'hABCD, 10'h002);
        step(4'h6, 4'h0, 16'h0000, 10'h001);
        step(4'h7, 4'hA, 16'hFFFF, 10'h000);
        step(4'h7, 4'h0, 16'h0000, 10'h000);
        cmd(4'hB, 4'h0, 16'h0155);
        step(4'h4, 4'h0, 16'hFFFF, 10'h0AA);
        step(4'h5, 4'h6, 16'h0000, 10'h055);
        step(4'h0, 4'hF, 16'hFFFF, 10'h055);
        step(4'hB, 4'h3, 16'h0100, 10'h055);
        step(4'h1, 4'h0, 16'h0000, 10'h123);
        check({47'h0, rd_pwr}, 48'h1);
        cmd(4'h0, 4'h0, 16'h0000);
        check({47'h0, rd_pwr}, 48'h0);
        cmd(4'hB, 4'h0, 16'h00AB);
        cmd(4'h2, 4'h0, 16'h0000);
        cmd(4'hB, 4'h0, 16'h0000);
        step(4'h8, 4'hF, 16'hFFFF, 10'h0AB);
        cmd(4'h3, 4'h0, 16'hFD44);
        step(4'h8, 4'h0, 16'h0000, 10'h144);
        cmd(4'h3, 4'h7, 16'hBEEF);
        cmd(4'h9, 4'h7, 16'h0000);
        cmd(4'h0, 4'h0, 16'h0000);
        check(got, 48'h97BEEF);
        cmd(4'hA, 4'h0, 16'h0000);
        cmd(4'h0, 4'h0, 16'h0000);
        check(got, 48'hA00144);
        cmd(4'hB, 4'h0, 16'h0155);
        step(4'hE, 4'h0, 16'h0000, 10'h156);
        check(got, 48'hB00155);
        u_host.xfer({24'hB00077, 24'hE00000}, 48, got);
        check(got, {24'hE00000, 24'hB00077});
        check({38'h0, wiper}, {38'h0, 10'h157});
        u_host.xfer({25'h0, 23'h5803C3}, 23, got);
        check({38'h0, wiper}, {38'h0, 10'h157});
        u_host.pulse();
        check({38'h0, wiper}, {38'h0, 10'h158});
        give_verdict();
    end
endmodule : testbench
